//--- rtl/sarctl_pkg.sv
// Purpose: Shared constants for the converter control and serial readout block.
// Assumes: System clock of 20 MHz; twelve-bit result sent in a sixteen-bit frame.
// Notes:   Cycle counts are derived from the printed times and the clock period.
package sarctl_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int RESULT_BITS = 12;
    localparam int WORD_BITS   = 16;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 50;
    localparam int CONV_TIME_NS    = 2200;
    localparam int DCLK_DELAY_NS   = 270;
    localparam int DCLK_CYCLE_NS   = 110;
    // All times round down, never below one cycle.
    localparam int CONV_CYCLES     = (CONV_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int DCLK_DLY_CYCLES = (DCLK_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 : DCLK_DELAY_NS / CLK_PERIOD_NS;
    localparam int DCLK_HALF_CYC   = (DCLK_CYCLE_NS / (2 * CLK_PERIOD_NS)) < 1 ? 1
                                     : DCLK_CYCLE_NS / (2 * CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [RESULT_BITS-1:0] RESULT_RST = 12'h000;
    localparam logic                   BUSY_RST   = 1'b1;

    // ------------------------------------------------------------
    // Conversion states
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        SARCTL_IDLE = 1'b0,
        SARCTL_CONV = 1'b1
    } sarctl_state_t;

endpackage

//--- rtl/sarctl_top.sv
// Purpose: Conversion control and serial readout for a twelve-bit sampling converter.
// Assumes: The converter core presents its result on conv_result_in at end of conversion.
// Notes:   The external serial clock is a second clock domain; reads cross by a gray count.
//          In external mode the tag pin passes three link flops before it reaches the data output.
`timescale 1ns/1ps

module sarctl_top (
    input  wire logic                                 clk_in,
    input  wire logic                                 rstn_in,
    input  wire logic                                 cs_n_in,
    input  wire logic                                 read_convert_in,
    input  wire logic                                 power_down_in,
    input  wire logic                                 clock_source_sel_in,
    input  wire logic                                 output_format_select_in,
    input  wire logic                                 tag_in,
    input  wire logic [sarctl_pkg::RESULT_BITS-1:0]   conv_result_in,
    input  wire logic                                 serial_clock_pin_in,
    output logic                                      serial_clock_pin_out,
    output logic                                      serial_clock_pin_oe_out,
    output logic                                      data_out,
    output logic                                      sync_out,
    output logic                                      busy_out,
    output logic                                      hold_out,
    output logic                                      low_power_out
);
    import sarctl_pkg::*;

    // ------------------------------------------------------------
    // System clock domain state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                   cs_s1;
        logic                   cs_s2;
        logic                   rc_s1;
        logic                   rc_s2;
        logic                   pd_s1;
        logic                   pd_s2;
        logic                   ext_s1;
        logic                   ext_s2;
        logic                   fmt_s1;
        logic                   fmt_s2;
        logic                   tag_s1;
        logic                   tag_s2;
        logic                   cvt_prev;
        logic                   rd_prev;
        sarctl_state_t          state;
        logic [7:0]             conv_cnt;
        logic                   busy;
        logic                   hold;
        logic                   low_power;
        logic [RESULT_BITS-1:0] result;
        logic [WORD_BITS-1:0]   tx_word;
        logic [1:0]             tx_seq;
        logic                   rd_act;
        logic [WORD_BITS-1:0]   int_shift;
        logic                   int_on;
        logic [3:0]             int_dly;
        logic [3:0]             int_half;
        logic [4:0]             int_edges;
        logic                   sclk;
        logic                   sclk_oe;
        logic                   int_data;
        logic                   tag_lat;
    } sarctl_sys_t;

    // ------------------------------------------------------------
    // Link clock domain state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                 rst_s1;
        logic                 rst_s2;
        logic [1:0]           seq_s1;
        logic [1:0]           seq_s2;
        logic [1:0]           seq_prev;
        logic                 tag_s1;
        logic                 tag_s2;
        logic                 act_s1;
        logic                 act_s2;
        logic [WORD_BITS-1:0] shift;
        logic [4:0]           cnt;
        logic                 sync;
        logic                 data;
    } sarctl_link_t;

    sarctl_sys_t  sys_q;
    sarctl_sys_t  sys_d;
    sarctl_link_t lnk_q;
    sarctl_link_t lnk_d;

    logic                 cvt_level;
    logic                 cvt_start;
    logic                 rd_level;
    logic                 rd_start;
    logic [WORD_BITS-1:0] fmt_word;

    // Gray order moves one bit per request, so the link side never reads a torn count.
    // Up to three read starts may pile up unseen while the host clock stands still.
    function automatic logic [1:0] gray_next(input logic [1:0] cur);
        gray_next = {cur[0], ~cur[1]};
    endfunction

    // ------------------------------------------------------------
    // Output word format
    // ------------------------------------------------------------
    // Two's complement of an offset-binary code is the same code with the top bit inverted.
    always_comb begin
        fmt_word = {sys_q.result, {(WORD_BITS-RESULT_BITS){1'b0}}};
        if (!sys_q.fmt_s2) begin
            fmt_word[WORD_BITS-1] = ~sys_q.result[RESULT_BITS-1];
        end
    end

    // ------------------------------------------------------------
    // Start and read detection
    // ------------------------------------------------------------
    // The OR of the two active-low controls is low only when both are low.
    assign cvt_level = ~(sys_q.cs_s2 | sys_q.rc_s2);
    // Start on the fall of the combined signal, whichever control fell second.
    assign cvt_start = cvt_level & ~sys_q.cvt_prev;
    // Read state is chip select low with read/convert high.
    assign rd_level  = ~sys_q.cs_s2 & sys_q.rc_s2;
    assign rd_start  = rd_level & ~sys_q.rd_prev;

    // ------------------------------------------------------------
    // System domain next state
    // ------------------------------------------------------------
    always_comb begin
        sys_d          = sys_q;

        // ------------------------------------------------------------
        // Input synchronisers
        // ------------------------------------------------------------
        sys_d.cs_s1    = cs_n_in;
        sys_d.cs_s2    = sys_q.cs_s1;
        sys_d.rc_s1    = read_convert_in;
        sys_d.rc_s2    = sys_q.rc_s1;
        sys_d.pd_s1    = power_down_in;
        sys_d.pd_s2    = sys_q.pd_s1;
        sys_d.ext_s1   = clock_source_sel_in;
        sys_d.ext_s2   = sys_q.ext_s1;
        sys_d.fmt_s1   = output_format_select_in;
        sys_d.fmt_s2   = sys_q.fmt_s1;
        sys_d.tag_s1   = tag_in;
        sys_d.tag_s2   = sys_q.tag_s1;
        sys_d.cvt_prev = cvt_level;
        sys_d.rd_prev  = rd_level;
        sys_d.rd_act   = rd_level;
        sys_d.low_power = sys_q.pd_s2;
        sys_d.sclk_oe   = ~sys_q.ext_s2;

        // ------------------------------------------------------------
        // Conversion state machine
        // ------------------------------------------------------------
        case (sys_q.state)
            SARCTL_IDLE: begin
                // Power-down refuses new starts; the stored result is not touched.
                if (cvt_start && !sys_q.pd_s2) begin
                    sys_d.state    = SARCTL_CONV;
                    sys_d.busy     = 1'b0;
                    sys_d.hold     = 1'b1;
                    sys_d.conv_cnt = 8'(CONV_CYCLES - 1);
                    sys_d.tag_lat  = sys_q.tag_s2;
                    if (!sys_q.ext_s2) begin
                        sys_d.int_on    = 1'b1;
                        sys_d.int_shift = fmt_word;
                        sys_d.int_data  = fmt_word[WORD_BITS-1];
                        sys_d.int_dly   = 4'(DCLK_DLY_CYCLES);
                        sys_d.int_half  = 4'(DCLK_HALF_CYC - 1);
                        sys_d.int_edges = 5'h00;
                        sys_d.sclk      = 1'b0;
                    end
                end
            end
            SARCTL_CONV: begin
                if (sys_q.conv_cnt == 8'h00) begin
                    // Busy returns high on the same edge that stores the new result.
                    sys_d.state  = SARCTL_IDLE;
                    sys_d.result = conv_result_in;
                    sys_d.busy   = 1'b1;
                    sys_d.hold   = 1'b0;
                end else begin
                    sys_d.conv_cnt = sys_q.conv_cnt - 8'h01;
                end
            end
            default: begin
                sys_d.state = SARCTL_IDLE;
                sys_d.busy  = 1'b1;
                sys_d.hold  = 1'b0;
            end
        endcase

        // ------------------------------------------------------------
        // Internal serial clock generator
        // ------------------------------------------------------------
        if (sys_q.int_on) begin
            if (sys_q.int_dly != 4'h0) begin
                sys_d.int_dly = sys_q.int_dly - 4'h1;
            end else if (sys_q.int_half != 4'h0) begin
                sys_d.int_half = sys_q.int_half - 4'h1;
            end else begin
                sys_d.int_half = 4'(DCLK_HALF_CYC - 1);
                if (sys_q.sclk) begin
                    // Data moves only on the falling edge, so it is stable across the rising edge.
                    sys_d.sclk      = 1'b0;
                    sys_d.int_edges = sys_q.int_edges + 5'h01;
                    if (sys_q.int_edges == 5'(WORD_BITS - 1)) begin
                        sys_d.int_on   = 1'b0;
                        sys_d.int_data = sys_q.tag_lat;
                    end else begin
                        sys_d.int_shift = {sys_q.int_shift[WORD_BITS-2:0], 1'b0};
                        sys_d.int_data  = sys_q.int_shift[WORD_BITS-2];
                    end
                end else begin
                    sys_d.sclk = 1'b1;
                end
            end
        end else begin
            sys_d.sclk = 1'b0;
        end

        // ------------------------------------------------------------
        // External read request toward the link domain
        // ------------------------------------------------------------
        // The word is frozen on the edge the count moves; the link side sees the count two flops later, so it reads the word settled.
        // A second read start before the host clock runs still shows as a change there.
        if (rd_start && sys_q.ext_s2) begin
            sys_d.tx_word = fmt_word;
            sys_d.tx_seq  = gray_next(sys_q.tx_seq);
        end

        // ------------------------------------------------------------
        // Synchronous reset
        // ------------------------------------------------------------
        // Control synchronisers start at the idle pin levels, so release shows no false edge.
        if (!rstn_in) begin
            sys_d           = '0;
            sys_d.state     = SARCTL_IDLE;
            sys_d.busy      = BUSY_RST;
            sys_d.hold      = 1'b0;
            sys_d.low_power = 1'b0;
            sys_d.result    = RESULT_RST;
            sys_d.tx_seq    = 2'h0;
            sys_d.cs_s1     = 1'b1;
            sys_d.cs_s2     = 1'b1;
            sys_d.rc_s1     = 1'b1;
            sys_d.rc_s2     = 1'b1;
            sys_d.cvt_prev  = 1'b0;
            sys_d.rd_prev   = 1'b0;
            sys_d.rd_act    = 1'b0;
            sys_d.int_on    = 1'b0;
            sys_d.int_edges = 5'h00;
            sys_d.int_data  = 1'b0;
            sys_d.tag_lat   = 1'b0;
            sys_d.sclk      = 1'b0;
            sys_d.sclk_oe   = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        sys_q <= sys_d;
    end

    // ------------------------------------------------------------
    // Link domain next state
    // ------------------------------------------------------------
    // The host clock may stop between frames; every step here waits for its next edge.
    always_comb begin
        lnk_d        = lnk_q;
        lnk_d.rst_s1 = rstn_in;
        lnk_d.rst_s2 = lnk_q.rst_s1;
        lnk_d.seq_s1   = sys_q.tx_seq;
        lnk_d.seq_s2   = lnk_q.seq_s1;
        lnk_d.seq_prev = lnk_q.seq_s2;
        lnk_d.act_s1   = sys_q.rd_act;
        lnk_d.act_s2   = lnk_q.act_s1;
        // The tag pin is synchronised like the rest; it only has to settle before the last two bits.
        lnk_d.tag_s1   = tag_in;
        lnk_d.tag_s2   = lnk_q.tag_s1;
        lnk_d.sync     = 1'b0;

        // ------------------------------------------------------------
        // Frame shifter
        // ------------------------------------------------------------
        if (lnk_q.seq_s2 != lnk_q.seq_prev) begin
            lnk_d.shift = sys_q.tx_word;
            lnk_d.data  = sys_q.tx_word[WORD_BITS-1];
            lnk_d.cnt   = 5'h01;
            lnk_d.sync  = 1'b1;
        end else if (lnk_q.cnt != 5'h00 && lnk_q.cnt < 5'(WORD_BITS)) begin
            lnk_d.shift = {lnk_q.shift[WORD_BITS-2:0], 1'b0};
            lnk_d.data  = lnk_q.shift[WORD_BITS-2];
            lnk_d.cnt   = lnk_q.cnt + 5'h01;
        end else if (lnk_q.cnt == 5'(WORD_BITS) && lnk_q.act_s2) begin
            lnk_d.data = lnk_q.tag_s2;
        end

        // ------------------------------------------------------------
        // Link reset
        // ------------------------------------------------------------
        if (!lnk_q.rst_s2) begin
            lnk_d.seq_prev = lnk_q.seq_s2;
            lnk_d.shift    = '0;
            lnk_d.cnt      = 5'h00;
            lnk_d.sync     = 1'b0;
            lnk_d.data     = 1'b0;
        end
    end

    always_ff @(posedge serial_clock_pin_in) begin
        lnk_q <= lnk_d;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Data is the one output taken from either domain's flop, chosen by the mode.
    // The mode select is settled long before a frame, so the mux never switches mid-bit.
    assign serial_clock_pin_out    = sys_q.sclk;
    assign serial_clock_pin_oe_out = sys_q.sclk_oe;
    assign data_out                = sys_q.ext_s2 ? lnk_q.data : sys_q.int_data;
    assign sync_out                = lnk_q.sync;
    assign busy_out                = sys_q.busy;
    assign hold_out                = sys_q.hold;
    assign low_power_out           = sys_q.low_power;

endmodule

//--- sim/sarctl_host_model.sv
// Purpose: Host serial port that clocks read frames out of the block.
// Assumes: The bench resolves the shared clock pin from the block's output enable.
// Notes:   The clock stands still between bursts, as a real host port does.
`timescale 1ns/1ps
module sarctl_host_model (
    input  wire logic        go_in,
    input  wire logic        data_in,
    input  wire logic        sync_in,
    output logic             sclk_out,
    output logic             done_out,
    output logic [23:0]      frame_out,
    output logic [23:0]      sync_seen_out
);
    initial begin
        sclk_out = 1'b0;
        done_out = 1'b0;
        frame_out = 24'h000000;
        sync_seen_out = 24'h000000;
        forever begin
            @(posedge go_in);
            done_out = 1'b0;
            // Samples on the falling edge, so a bit launched late in the high phase still lands.
            repeat (24) begin
                sclk_out = 1'b1;
                #62.5;
                sclk_out = 1'b0;
                frame_out = {frame_out[22:0], data_in};
                sync_seen_out = {sync_seen_out[22:0], sync_in};
                #62.5;
            end
            done_out = 1'b1;
        end
    end
endmodule

//--- sim/sarctl_top_asserts.sv
// Purpose: Port assertions for the converter control block.
// Assumes: Controls are held several clocks around each change.
// Notes:   Link-domain frame timing is judged by the bench instead.
`timescale 1ns/1ps
module sarctl_top_asserts (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic cs_n_in,
    input wire logic read_convert_in,
    input wire logic power_down_in,
    input wire logic clock_source_sel_in,
    input wire logic serial_clock_pin_out,
    input wire logic serial_clock_pin_oe_out,
    input wire logic data_out,
    input wire logic busy_out,
    input wire logic hold_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    property p_busy_hold; busy_out == !hold_out; endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy and hold disagree");
    property p_busy_len; $fell(busy_out) |-> ##43 !busy_out ##1 busy_out; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy low time wrong");
    property p_busy_end; $rose(busy_out) |-> $past(busy_out, 45) && !$past(busy_out, 44); endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy rose early");
    property p_start; $fell(busy_out) |-> !$past(cs_n_in) && !$past(read_convert_in); endproperty
    a_start: assert property (p_start) else $error("start without both controls low");
    property p_pd; power_down_in [*8] |-> !$fell(busy_out); endproperty
    a_pd: assert property (p_pd) else $error("start during power down");
    property p_oe_ext; clock_source_sel_in [*5] |-> !serial_clock_pin_oe_out; endproperty
    a_oe_ext: assert property (p_oe_ext) else $error("pin driven in external mode");
    property p_oe_int; !clock_source_sel_in [*5] |-> serial_clock_pin_oe_out; endproperty
    a_oe_int: assert property (p_oe_int) else $error("pin not driven in internal mode");
    property p_sclk_idle; busy_out |-> !serial_clock_pin_out; endproperty
    a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock runs while idle");
    property p_sclk_pulse; $rose(serial_clock_pin_out) |=> $fell(serial_clock_pin_out); endproperty
    a_sclk_pulse: assert property (p_sclk_pulse) else $error("serial clock pulse shape");
    property p_first; $fell(busy_out) && serial_clock_pin_oe_out |-> !serial_clock_pin_out [*6] ##1 serial_clock_pin_out;
    endproperty
    a_first: assert property (p_first) else $error("first serial clock misplaced");
    property p_bit; $rose(serial_clock_pin_out) && serial_clock_pin_oe_out |-> $stable(data_out); endproperty
    a_bit: assert property (p_bit) else $error("data moved at rising clock");
endmodule
bind sarctl_top sarctl_top_asserts u_chk (.clk_in(clk_in), .rstn_in(rstn_in), .cs_n_in(cs_n_in),
    .read_convert_in(read_convert_in), .power_down_in(power_down_in), .clock_source_sel_in(clock_source_sel_in),
    .serial_clock_pin_out(serial_clock_pin_out), .serial_clock_pin_oe_out(serial_clock_pin_oe_out),
    .data_out(data_out), .busy_out(busy_out), .hold_out(hold_out));

//--- sim/sarctl_top_test.sv
// Purpose: Self-checking bench for the converter control block.
// Assumes: The host model runs the serial clock only inside read bursts.
// Notes:   Controls are held several clocks so the input synchronisers settle.
`timescale 1ns/1ps
module sarctl_top_test;
    import sarctl_pkg::*;
    logic                   clk_in, rstn_in, cs_n, rc, pd, sel, fmt, tag, go;
    logic                   sclk_o, oe, dat, sync, busy, hold, lowp, host_clk, done, pin;
    logic [RESULT_BITS-1:0] res, prev;
    logic [23:0]            frame, syncs;
    logic [15:0]            bits;
    int                     num_errors, comparisons, cycles, i, n;
    assign pin = oe ? sclk_o : host_clk;
    sarctl_top u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .cs_n_in(cs_n), .read_convert_in(rc),
        .power_down_in(pd), .clock_source_sel_in(sel), .output_format_select_in(fmt), .tag_in(tag),
        .conv_result_in(res), .serial_clock_pin_in(pin), .serial_clock_pin_out(sclk_o),
        .serial_clock_pin_oe_out(oe), .data_out(dat), .sync_out(sync), .busy_out(busy),
        .hold_out(hold), .low_power_out(lowp));
    sarctl_host_model u_host (.go_in(go), .data_in(dat), .sync_in(sync), .sclk_out(host_clk),
        .done_out(done), .frame_out(frame), .sync_seen_out(syncs));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] word(input logic [11:0] r, input logic f);
        word = {f ? r[11] : ~r[11], r[10:0], 4'h0};
    endfunction
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_in);
        #5;
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Leaves chip select low and read/convert high, which is a read start in external mode.
    task automatic convert(input logic cs_first);
        if (cs_first) cs_n = 1'b0;
        else rc = 1'b0;
        tick(3);
        if (cs_first) rc = 1'b0;
        else cs_n = 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 10) begin
            tick(1);
            n++;
        end
        n = 0;
        bits = 16'h0000;
        while (busy === 1'b0 && n < 60) begin
            if (sclk_o === 1'b1) bits = {bits[14:0], dat};
            tick(1);
            n++;
        end
        rc = 1'b1;
        tick(4);
    endtask
    task automatic read(input logic [11:0] r);
        go = 1'b1;
        tick(1);
        n = 0;
        while (done !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        go = 1'b0;
        check("ext frame", {2'b00, frame[21:0]}, {2'b00, word(r, fmt), {6{tag}}});
        check("sync", syncs, 24'h200000);
    endtask
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {cs_n, rc, pd, sel, fmt, tag, go, rstn_in} = 8'hD8;
        res = 12'h000;
        prev = RESULT_RST;
        void'($urandom(32'hB8C1A71A));
        #1 go = 1'b1;
        repeat (6) @(posedge clk_in);
        #5 rstn_in = 1'b1;
        go = 1'b0;
        check("reset busy", 24'(busy), 24'h1);
        tick(3);
        for (i = 0; i < 10; i++) begin
            {res, fmt, tag} = 14'($urandom);
            if (i < 2) res = {12{i[0]}};
            sel = i[0];
            tick(6);
            convert(i[1]);
            check("busy low", 24'(n), 24'(CONV_CYCLES));
            if (sel === 1'b0) begin
                check("int frame", 24'(bits), 24'(word(prev, fmt)));
                check("int idle", 24'(dat), 24'(tag));
            end else begin
                read(res);
            end
            prev = res;
            cs_n = 1'b1;
            tick(4);
            $display("test %0d done", i);
        end
        pd = 1'b1;
        tick(8);
        check("low power", 24'(lowp), 24'h1);
        res = ~prev;
        convert(1'b0);
        check("refused", 24'(n), 24'h0);
        read(prev);
        pd = 1'b0;
        cs_n = 1'b1;
        tick(8);
        cs_n = 1'b0;
        tick(4);
        read(prev);
        cs_n = 1'b1;
        $display("test power down and select read done");
        summarize();
    end
endmodule
